/* File: logic/tmr_channel.sv */
// one 16-bit timer channel: counter, compare, capture, buffers, flags
// What this block does
// - in normal pair mode, buffered compare register reloads from its buffer at each compare match
// - buffered capture loads counter, old general value moves to buffer
// - complementary pair mode reloads from buffer at counter direction reversal
// - reset-synchronized pair mode reloads from buffer at pair period match
// - counter counts only while this channel's run bit is set
// - after reset counter is a free-running up-counter, no clear source
// - wrap from maximum to zero sets wrap flag, interrupt if enabled
// - periodic match sets flag, clears counter, interrupt if enabled
// - clock select picks system clock, divided by 2, 4, 8, or pin
// - edge select counts rising, falling or both pin edges
// - match drives pin low, high or toggle; channel 2 cannot toggle
// - a match asking for the level already present leaves pin alone
// - match fires in last equal cycle, when counter leaves the value
// - at match the selected level is driven on the matching pin
// - selected pin edge latches counter into its general register
// - capture into register B may clear the counter
// - clear source picks compare A, compare B, or no clearing
// - flag clears only by reading it as one then writing zero
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "tmr_defs.svh"
`default_nettype none

module tmr_channel
#(
    parameter int CHAN = 0
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic ext_count_clock_pin,
    input wire logic capture_compare_pin_a_in,
    output logic capture_compare_pin_a_out,
    output logic capture_compare_pin_a_oe,
    input wire logic capture_compare_pin_b_in,
    output logic capture_compare_pin_b_out,
    output logic capture_compare_pin_b_oe,
    input wire logic pair_dir_reverse,
    input wire logic pair_period_match,
    output logic irq_match_a,
    output logic irq_match_b,
    output logic irq_wrap
);
    // ==========================================================
    // functions
    function automatic logic tmr_level(input tmr_pkg::tmr_act_t act,
                                       input logic cur);
        logic lvl;
        lvl = cur;
        unique case (act)
            tmr_pkg::TMR_ACT_HOLD: lvl = cur;
            tmr_pkg::TMR_ACT_LOW: lvl = 1'b0;
            tmr_pkg::TMR_ACT_HIGH: lvl = 1'b1;
            // no toggle on channel 2: hold instead
            tmr_pkg::TMR_ACT_TOGGLE: lvl = (CHAN == 2) ? cur : ~cur;
        endcase
        return lvl;
    endfunction

    // ==========================================================
    // state
    logic [4:0] start_control_reg_q;
    logic [6:0] channel_control_reg_q;
    logic [9:0] pin_function_reg_q;
    logic [2:0] irq_enable_reg_q;
    logic [2:0] status_flags_reg_q;
    logic [2:0] armed_q;
    logic [3:0] buf_mode_reg_q;
    logic [15:0] channel_counter_q;
    logic [15:0] general_reg_a_q;
    logic [15:0] general_reg_b_q;
    logic [15:0] buffer_reg_a_q;
    logic [15:0] buffer_reg_b_q;
    logic [2:0] presc_q;
    logic pin_a_q;
    logic pin_b_q;
    logic oe_a_q;
    logic oe_b_q;
    logic [15:0] rdata_q;
    logic [2:0] irq_q;

    // ==========================================================
    // pin edge detectors
    tmr_edge_if ext_eif();
    tmr_edge_if cap_a_eif();
    tmr_edge_if cap_b_eif();

    tmr_pin_edge u_ext_edge
    (
        .clk(clk),
        .nrst(nrst),
        .pin(ext_count_clock_pin),
        .eif(ext_eif)
    );

    tmr_pin_edge u_cap_a_edge
    (
        .clk(clk),
        .nrst(nrst),
        .pin(capture_compare_pin_a_in),
        .eif(cap_a_eif)
    );

    tmr_pin_edge u_cap_b_edge
    (
        .clk(clk),
        .nrst(nrst),
        .pin(capture_compare_pin_b_in),
        .eif(cap_b_eif)
    );

    // ==========================================================
    // field decode
    wire run = start_control_reg_q[CHAN];
    wire [2:0] clk_sel =
        channel_control_reg_q[`TMR_CKS_MSB:`TMR_CKS_LSB];
    wire tmr_pkg::tmr_clr_t clr_src = tmr_pkg::tmr_clr_t'(
        channel_control_reg_q[`TMR_CLR_MSB:`TMR_CLR_LSB]);
    wire tmr_pkg::tmr_act_t act_a = tmr_pkg::tmr_act_t'(
        pin_function_reg_q[`TMR_ACTA_MSB:`TMR_ACTA_LSB]);
    wire tmr_pkg::tmr_act_t act_b = tmr_pkg::tmr_act_t'(
        pin_function_reg_q[`TMR_ACTB_MSB:`TMR_ACTB_LSB]);
    wire cap_mode_a = pin_function_reg_q[`TMR_CAPA_BIT];
    wire cap_mode_b = pin_function_reg_q[`TMR_CAPB_BIT];
    wire buf_a = buf_mode_reg_q[`TMR_BUFA_BIT];
    wire buf_b = buf_mode_reg_q[`TMR_BUFB_BIT];
    wire tmr_pkg::tmr_mode_t pair_mode = tmr_pkg::tmr_mode_t'(
        buf_mode_reg_q[`TMR_MODE_MSB:`TMR_MODE_LSB]);

    assign ext_eif.sel =
        channel_control_reg_q[`TMR_EDGE_MSB:`TMR_EDGE_LSB];
    assign cap_a_eif.sel =
        pin_function_reg_q[`TMR_CEDA_MSB:`TMR_CEDA_LSB];
    assign cap_b_eif.sel =
        pin_function_reg_q[`TMR_CEDB_MSB:`TMR_CEDB_LSB];

    // register port decode
    wire wr_start = reg_wr & (reg_addr == `TMR_OFS_START);
    wire wr_ctrl = reg_wr & (reg_addr == `TMR_OFS_CTRL);
    wire wr_pinf = reg_wr & (reg_addr == `TMR_OFS_PINF);
    wire wr_ier = reg_wr & (reg_addr == `TMR_OFS_IER);
    wire wr_flags = reg_wr & (reg_addr == `TMR_OFS_FLAGS);
    wire wr_cnt = reg_wr & (reg_addr == `TMR_OFS_CNT);
    wire wr_gra = reg_wr & (reg_addr == `TMR_OFS_GRA);
    wire wr_grb = reg_wr & (reg_addr == `TMR_OFS_GRB);
    wire wr_bra = reg_wr & (reg_addr == `TMR_OFS_BRA);
    wire wr_brb = reg_wr & (reg_addr == `TMR_OFS_BRB);
    wire wr_bmode = reg_wr & (reg_addr == `TMR_OFS_BMODE);
    wire rd_flags = reg_rd & (reg_addr == `TMR_OFS_FLAGS);

    // ==========================================================
    // count source
    // prescaler runs free so a /N tick lands on a fixed phase
    wire int_tick = (clk_sel == `TMR_CKS_DIV1) |
                    ((clk_sel == `TMR_CKS_DIV2) & presc_q[0]) |
                    ((clk_sel == `TMR_CKS_DIV4) & (&presc_q[1:0])) |
                    ((clk_sel == `TMR_CKS_DIV8) & (&presc_q));
    wire tick = run & (clk_sel[2] ? ext_eif.hit : int_tick);

    // ==========================================================
    // compare, capture, clear
    // match fires only when the counter is about to leave the value
    wire cmp_a = tick & ~cap_mode_a &
                 (channel_counter_q == general_reg_a_q);
    wire cmp_b = tick & ~cap_mode_b &
                 (channel_counter_q == general_reg_b_q);
    wire cap_a = cap_mode_a & cap_a_eif.hit;
    wire cap_b = cap_mode_b & cap_b_eif.hit;
    wire clr_now = ((clr_src == tmr_pkg::TMR_CLR_A) & (cmp_a | cap_a)) |
                   ((clr_src == tmr_pkg::TMR_CLR_B) &
                    (cmp_b | cap_b));
    wire wrap = tick & ~clr_now &
                (channel_counter_q == `TMR_CNT_MAX);

    wire [15:0] cnt_d = wr_cnt ? reg_wdata :
                        clr_now ? `TMR_CNT_RST :
                        tick ? channel_counter_q + 16'h0001 :
                        channel_counter_q;

    // buffer transfer point depends on pairing mode
    wire xfer_a = (pair_mode == tmr_pkg::TMR_MODE_NORMAL) ? cmp_a :
                  (pair_mode == tmr_pkg::TMR_MODE_RSYNC) ?
                  pair_period_match :
                  (pair_mode == tmr_pkg::TMR_MODE_COMPL) &
                  pair_dir_reverse;
    wire xfer_b = (pair_mode == tmr_pkg::TMR_MODE_NORMAL) ? cmp_b :
                  (pair_mode == tmr_pkg::TMR_MODE_RSYNC) ?
                  pair_period_match :
                  (pair_mode == tmr_pkg::TMR_MODE_COMPL) &
                  pair_dir_reverse;

    wire [15:0] gra_d = wr_gra ? reg_wdata :
                        cap_a ? channel_counter_q :
                        (buf_a & ~cap_mode_a & xfer_a) ? buffer_reg_a_q :
                        general_reg_a_q;
    wire [15:0] grb_d = wr_grb ? reg_wdata :
                        cap_b ? channel_counter_q :
                        (buf_b & ~cap_mode_b & xfer_b) ? buffer_reg_b_q :
                        general_reg_b_q;
    wire [15:0] bra_d = wr_bra ? reg_wdata :
                        (cap_a & buf_a) ? general_reg_a_q :
                        buffer_reg_a_q;
    wire [15:0] brb_d = wr_brb ? reg_wdata :
                        (cap_b & buf_b) ? general_reg_b_q :
                        buffer_reg_b_q;

    // ==========================================================
    // flags: a set in the clearing cycle wins
    wire [2:0] flag_set = {wrap, cmp_b | cap_b, cmp_a | cap_a};
    wire [2:0] flag_clr = {3{wr_flags}} & ~reg_wdata[2:0] & armed_q;
    wire [2:0] flags_d = flag_set | (status_flags_reg_q & ~flag_clr);
    wire [2:0] armed_d = (armed_q | ({3{rd_flags}} & status_flags_reg_q)) &
                         ~flag_clr;

    // ==========================================================
    // output pins
    wire pin_a_d = cmp_a ? tmr_level(act_a, pin_a_q) : pin_a_q;
    wire pin_b_d = cmp_b ? tmr_level(act_b, pin_b_q) : pin_b_q;

    // ==========================================================
    // read mux; reserved enable bits 7:3 read as one
    wire [15:0] rd_mux =
        (reg_addr == `TMR_OFS_START) ? {11'h000, start_control_reg_q} :
        (reg_addr == `TMR_OFS_CTRL) ? {9'h000, channel_control_reg_q} :
        (reg_addr == `TMR_OFS_PINF) ? {6'h00, pin_function_reg_q} :
        (reg_addr == `TMR_OFS_IER) ? (`TMR_IER_PAD |
                                      {13'h0000, irq_enable_reg_q}) :
        (reg_addr == `TMR_OFS_FLAGS) ? {13'h0000, status_flags_reg_q} :
        (reg_addr == `TMR_OFS_CNT) ? channel_counter_q :
        (reg_addr == `TMR_OFS_GRA) ? general_reg_a_q :
        (reg_addr == `TMR_OFS_GRB) ? general_reg_b_q :
        (reg_addr == `TMR_OFS_BRA) ? buffer_reg_a_q :
        (reg_addr == `TMR_OFS_BRB) ? buffer_reg_b_q :
        (reg_addr == `TMR_OFS_BMODE) ? {12'h000, buf_mode_reg_q} :
        16'h0000;

    // ==========================================================
    // software registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            start_control_reg_q <= `TMR_START_RST;
            channel_control_reg_q <= `TMR_CTRL_RST;
            pin_function_reg_q <= `TMR_PINF_RST;
            irq_enable_reg_q <= `TMR_IER_RST;
            buf_mode_reg_q <= `TMR_BMODE_RST;
        end
        else
        begin
            if (wr_start)
                start_control_reg_q <= reg_wdata[4:0];
            if (wr_ctrl)
                channel_control_reg_q <= reg_wdata[6:0];
            if (wr_pinf)
                pin_function_reg_q <= reg_wdata[9:0];
            if (wr_ier)
                irq_enable_reg_q <= reg_wdata[2:0];
            if (wr_bmode)
                buf_mode_reg_q <= reg_wdata[3:0];
        end
    end

    // timing state
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            presc_q <= 3'h0;
            channel_counter_q <= `TMR_CNT_RST;
            general_reg_a_q <= `TMR_GR_RST;
            general_reg_b_q <= `TMR_GR_RST;
            buffer_reg_a_q <= `TMR_GR_RST;
            buffer_reg_b_q <= `TMR_GR_RST;
            status_flags_reg_q <= `TMR_FLAGS_RST;
            armed_q <= 3'h0;
        end
        else
        begin
            presc_q <= presc_q + 3'h1;
            channel_counter_q <= cnt_d;
            general_reg_a_q <= gra_d;
            general_reg_b_q <= grb_d;
            buffer_reg_a_q <= bra_d;
            buffer_reg_b_q <= brb_d;
            status_flags_reg_q <= flags_d;
            armed_q <= armed_d;
        end
    end

    // outputs
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            oe_a_q <= 1'b0;
            oe_b_q <= 1'b0;
            rdata_q <= 16'h0000;
            irq_q <= 3'h0;
        end
        else
        begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            oe_a_q <= ~cap_mode_a & (act_a != tmr_pkg::TMR_ACT_HOLD);
            oe_b_q <= ~cap_mode_b & (act_b != tmr_pkg::TMR_ACT_HOLD);
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
            irq_q <= flags_d & irq_enable_reg_q;
        end
    end

    assign capture_compare_pin_a_out = pin_a_q;
    assign capture_compare_pin_b_out = pin_b_q;
    assign capture_compare_pin_a_oe = oe_a_q;
    assign capture_compare_pin_b_oe = oe_b_q;
    assign reg_rdata = rdata_q;
    assign irq_match_a = irq_q[`TMR_FLAG_A];
    assign irq_match_b = irq_q[`TMR_FLAG_B];
    assign irq_wrap = irq_q[`TMR_FLAG_WRAP];

    // ==========================================================
    // checks
    run_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (!run && !wr_cnt && !cap_a && !cap_b) |=> $stable(channel_counter_q))
        else $error("counter moved while stopped");

    wrap_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        (wrap && !wr_cnt) |=> (channel_counter_q == 16'h0000) &&
        status_flags_reg_q[`TMR_FLAG_WRAP])
        else $error("wrap did not zero counter and set flag");

    period_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmp_a && clr_src == tmr_pkg::TMR_CLR_A && !wr_cnt) |=>
        (channel_counter_q == 16'h0000) && status_flags_reg_q[`TMR_FLAG_A])
        else $error("periodic match did not clear counter");

    pin_cause_a: assert property (@(posedge clk) disable iff (!nrst)
        $changed(pin_a_q) |-> $past(tick) &&
        ($past(channel_counter_q) == $past(general_reg_a_q)))
        else $error("pin a changed without a match");

    toggle_rule_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmp_a && act_a == tmr_pkg::TMR_ACT_TOGGLE) |=>
        (pin_a_q == ((CHAN == 2) ? $past(pin_a_q) : !$past(pin_a_q))))
        else $error("toggle output wrong for this channel");

    buf_reload_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmp_a && buf_a && pair_mode == tmr_pkg::TMR_MODE_NORMAL &&
        !wr_gra) |=> general_reg_a_q == $past(buffer_reg_a_q))
        else $error("buffer not reloaded at match");

    cap_shift_a: assert property (@(posedge clk) disable iff (!nrst)
        (cap_a && buf_a && !wr_gra && !wr_bra) |=>
        (general_reg_a_q == $past(channel_counter_q)) &&
        (buffer_reg_a_q == $past(general_reg_a_q)))
        else $error("capture did not shift into buffer");

    flag_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        (status_flags_reg_q[`TMR_FLAG_A] && !armed_q[`TMR_FLAG_A] &&
        wr_flags) |=> status_flags_reg_q[`TMR_FLAG_A])
        else $error("flag cleared without prior read");

    cap_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (cap_b && clr_src == tmr_pkg::TMR_CLR_B && !wr_cnt) |=>
        channel_counter_q == 16'h0000)
        else $error("capture b did not clear counter");
endmodule

`default_nettype wire

/* File: logic/tmr_defs.svh */
// register offsets, field positions, reset values of the timer channel
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ==========================================================
// register offsets (word index on the register port)
`define TMR_OFS_START 4'h0
`define TMR_OFS_CTRL 4'h1
`define TMR_OFS_PINF 4'h2
`define TMR_OFS_IER 4'h3
`define TMR_OFS_FLAGS 4'h4
`define TMR_OFS_CNT 4'h5
`define TMR_OFS_GRA 4'h6
`define TMR_OFS_GRB 4'h7
`define TMR_OFS_BRA 4'h8
`define TMR_OFS_BRB 4'h9
`define TMR_OFS_BMODE 4'hA

// ==========================================================
// channel_control_reg fields
`define TMR_CKS_LSB 0
`define TMR_CKS_MSB 2
`define TMR_EDGE_LSB 3
`define TMR_EDGE_MSB 4
`define TMR_CLR_LSB 5
`define TMR_CLR_MSB 6

// pin_function_reg fields
`define TMR_ACTA_LSB 0
`define TMR_ACTA_MSB 1
`define TMR_CAPA_BIT 2
`define TMR_CEDA_LSB 3
`define TMR_CEDA_MSB 4
`define TMR_ACTB_LSB 5
`define TMR_ACTB_MSB 6
`define TMR_CAPB_BIT 7
`define TMR_CEDB_LSB 8
`define TMR_CEDB_MSB 9

// buffer mode register fields
`define TMR_BUFA_BIT 0
`define TMR_BUFB_BIT 1
`define TMR_MODE_LSB 2
`define TMR_MODE_MSB 3

// flag and enable bit positions
`define TMR_FLAG_A 0
`define TMR_FLAG_B 1
`define TMR_FLAG_WRAP 2

// ==========================================================
// reset values
`define TMR_START_RST 5'h00
`define TMR_CTRL_RST 7'h00
`define TMR_PINF_RST 10'h000
`define TMR_IER_RST 3'h0
`define TMR_FLAGS_RST 3'h0
`define TMR_BMODE_RST 4'h0
`define TMR_CNT_RST 16'h0000
`define TMR_GR_RST 16'hFFFF
`define TMR_CNT_MAX 16'hFFFF
`define TMR_IER_PAD 16'h00F8

// ==========================================================
// clock select and edge codes
`define TMR_CKS_DIV1 3'h0
`define TMR_CKS_DIV2 3'h1
`define TMR_CKS_DIV4 3'h2
`define TMR_CKS_DIV8 3'h3
`define TMR_EDGE_RISE 2'h0
`define TMR_EDGE_FALL 2'h1

`endif

/* File: logic/tmr_pkg.sv */
// types shared by the timer channel files
`default_nettype none

package tmr_pkg;

    typedef enum logic [1:0] {
        TMR_ACT_HOLD = 2'h0,
        TMR_ACT_LOW = 2'h1,
        TMR_ACT_HIGH = 2'h2,
        TMR_ACT_TOGGLE = 2'h3
    } tmr_act_t;

    typedef enum logic [1:0] {
        TMR_CLR_NONE = 2'h0,
        TMR_CLR_A = 2'h1,
        TMR_CLR_B = 2'h2,
        TMR_CLR_RSVD = 2'h3
    } tmr_clr_t;

    typedef enum logic [1:0] {
        TMR_MODE_NORMAL = 2'h0,
        TMR_MODE_RSYNC = 2'h1,
        TMR_MODE_COMPL = 2'h3,
        TMR_MODE_RSVD = 2'h2
    } tmr_mode_t;

endpackage

`default_nettype wire

/* File: logic/tmr_edge_if.sv */
// edge select in, edge hit out, between channel and pin edge detector
`timescale 1ns/10ps
`default_nettype none

interface tmr_edge_if;
    logic [1:0] sel;
    logic hit;
    modport det (input sel, output hit);
    modport user (output sel, input hit);
endinterface

`default_nettype wire

/* File: logic/tmr_pin_edge.sv */
// pin synchroniser with rising, falling or both-edge detection
`timescale 1ns/10ps
`include "tmr_defs.svh"
`default_nettype none

module tmr_pin_edge
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    tmr_edge_if.det eif
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [1:0] fill_q;
    wire rise;
    wire fall;
    wire live;

    // meta_q feeds only sync_q; no reset, so a pin idling high
    // cannot look like a fresh edge once reset is released
    always_ff @(posedge clk)
    begin
        meta_q <= pin;
        sync_q <= meta_q;
        prev_q <= sync_q;
    end

    // edges stay masked until the pipeline has refilled after reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
            fill_q <= 2'h0;
        else if (!live)
            fill_q <= fill_q + 2'h1;
    end

    assign live = (fill_q == 2'h3);
    assign rise = live & sync_q & ~prev_q;
    assign fall = live & ~sync_q & prev_q;
    assign eif.hit = (eif.sel == `TMR_EDGE_RISE) ? rise :
                     (eif.sel == `TMR_EDGE_FALL) ? fall : (rise | fall);
endmodule

`default_nettype wire

/* File: tb/tmr_pin_drv.sv */
// pin-side model: external count clock and capture inputs
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// pin driver
module tmr_pin_drv
(
    input wire logic clk,
    output var logic ext_clk,
    output var logic cap_a,
    output var logic cap_b
);
    initial
    begin
        ext_clk = 1'b0;
        cap_a = 1'b0;
        cap_b = 1'b0;
    end

    // 3-clock high and 4-clock low phases clear the 2.5-clock both-edge minimum
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk) ext_clk <= 1'b1;
            repeat (3) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic caps(input logic a, input logic b);
        @(posedge clk) cap_a <= a;
        cap_b <= b;
    endtask
endmodule

`default_nettype wire

/* File: tb/tb_timer_channel_basic_functions.sv */
// self-checking bench for one timer channel
`timescale 1ns/10ps
`include "tmr_defs.svh"
`default_nettype none

// ==========================================================
// bench top
module tb_timer_channel_basic_functions;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pair_rev = 1'b0;
    logic pair_per = 1'b0;
    logic [15:0] rdata, v, w;
    logic ext_clk, cap_a, cap_b, pa_out, pa_oe, pb_out, pb_oe;
    logic irq_a, irq_b, irq_w;
    logic pa_prev = 1'b0;
    int failures = 0;
    int tests_run = 0;
    int toggles = 0;
    int t0;

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        pa_prev <= pa_out;
        if (pa_out !== pa_prev)
            toggles <= toggles + 1;
    end

    tmr_channel #(.CHAN(0)) u_dut (.clk(clk), .nrst(nrst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .ext_count_clock_pin(ext_clk),
        .capture_compare_pin_a_in(cap_a),
        .capture_compare_pin_a_out(pa_out),
        .capture_compare_pin_a_oe(pa_oe),
        .capture_compare_pin_b_in(cap_b),
        .capture_compare_pin_b_out(pb_out),
        .capture_compare_pin_b_oe(pb_oe),
        .pair_dir_reverse(pair_rev), .pair_period_match(pair_per),
        .irq_match_a(irq_a), .irq_match_b(irq_b), .irq_wrap(irq_w));

    tmr_pin_drv u_pins (.clk(clk), .ext_clk(ext_clk), .cap_a(cap_a),
        .cap_b(cap_b));

    // ======================================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one-cycle pulse on direction reversal, else on period match
    task automatic pulse_pair(input logic rev);
        @(posedge clk);
        pair_rev <= rev;
        pair_per <= ~rev;
        @(posedge clk);
        pair_rev <= 1'b0;
        pair_per <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        failures++;
        final_report();
    end

    // ======================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_reset", v, `TMR_GR_RST);
        rd_reg(`TMR_OFS_CTRL, v);
        chk("ctrl_reset", v, 16'h0000);
        cyc(20);
        rd_reg(`TMR_OFS_CNT, v);
        chk("cnt_idle", v, 16'h0000);
        rd_reg(`TMR_OFS_IER, v);
        chk("ier_reset", v, `TMR_IER_PAD);
        rd_reg(4'hB, v);
        chk("unmapped", v, 16'h0000);
        $display("reset test done");

        wr_reg(`TMR_OFS_IER, 16'h0004);
        wr_reg(`TMR_OFS_CNT, 16'hFFFE);
        wr_reg(`TMR_OFS_START, 16'h0001);
        cyc(5);
        wr_reg(`TMR_OFS_START, 16'h0000);
        chk("irq_wrap", {15'h0, irq_w}, 16'h0001);
        rd_reg(`TMR_OFS_CNT, v);
        chk("cnt_wrapped", {15'h0, v < 16'h0010}, 16'h0001);
        cyc(10);
        rd_reg(`TMR_OFS_CNT, w);
        chk("cnt_held", w, v);
        wr_reg(`TMR_OFS_START, 16'h0001);
        cyc(4);
        rd_reg(`TMR_OFS_CNT, w);
        chk("cnt_resumed", {15'h0, w > v}, 16'h0001);
        wr_reg(`TMR_OFS_START, 16'h0000);
        // the write before any read must not clear
        wr_reg(`TMR_OFS_FLAGS, 16'h0000);
        rd_reg(`TMR_OFS_FLAGS, v);
        chk("flag_kept", v, 16'h0007);
        wr_reg(`TMR_OFS_FLAGS, 16'h0000);
        rd_reg(`TMR_OFS_FLAGS, v);
        chk("flag_cleared", v, 16'h0000);
        chk("irq_wrap_off", {15'h0, irq_w}, 16'h0000);
        $display("wrap test done");

        wr_reg(`TMR_OFS_GRA, 16'h0003);
        wr_reg(`TMR_OFS_GRB, 16'h0002);
        wr_reg(`TMR_OFS_BRA, 16'h0005);
        wr_reg(`TMR_OFS_BMODE, 16'h0001);
        wr_reg(`TMR_OFS_CNT, 16'h0000);
        wr_reg(`TMR_OFS_CTRL, 16'h0020);
        wr_reg(`TMR_OFS_PINF, 16'h0042);
        wr_reg(`TMR_OFS_IER, 16'h0003);
        wr_reg(`TMR_OFS_START, 16'h0001);
        cyc(30);
        chk("pin_high", {14'h0, pa_oe, pa_out}, 16'h0003);
        chk("pin_b_high", {14'h0, pb_oe, pb_out}, 16'h0003);
        chk("irq_b", {15'h0, irq_b}, 16'h0001);
        chk("irq_a", {15'h0, irq_a}, 16'h0001);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_reload", v, 16'h0005);
        rd_reg(`TMR_OFS_CNT, v);
        chk("cnt_period", {15'h0, v <= 16'h0005}, 16'h0001);
        wr_reg(`TMR_OFS_PINF, 16'h0003);
        t0 = toggles;
        cyc(60);
        // period of six clocks: match in last equal cycle, then clear
        v = 16'(toggles - t0);
        chk("toggles", {15'h0, v >= 9 && v <= 11}, 16'h0001);
        wr_reg(`TMR_OFS_PINF, 16'h0001);
        cyc(12);
        chk("pin_low", {15'h0, pa_out}, 16'h0000);
        t0 = toggles;
        cyc(12);
        chk("pin_same", 16'(toggles - t0), 16'h0000);
        $display("compare test done");

        for (int k = 1; k < 4; k++)
        begin
            wr_reg(`TMR_OFS_START, 16'h0000);
            wr_reg(`TMR_OFS_CTRL, 16'(k));
            wr_reg(`TMR_OFS_CNT, 16'h0000);
            wr_reg(`TMR_OFS_START, 16'h0001);
            cyc(80);
            wr_reg(`TMR_OFS_START, 16'h0000);
            rd_reg(`TMR_OFS_CNT, v);
            w = 16'(80 >> k);
            chk("prescale", {15'h0, v >= w - 1 && v <= w + 3}, 16'h0001);
        end
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(`TMR_OFS_CTRL, 16'h0004 | 16'(k << 3));
            wr_reg(`TMR_OFS_CNT, 16'h0000);
            wr_reg(`TMR_OFS_START, 16'h0001);
            u_pins.pulses(3);
            cyc(6);
            wr_reg(`TMR_OFS_START, 16'h0000);
            rd_reg(`TMR_OFS_CNT, v);
            chk("ext_count", v, (k == 2) ? 16'h0006 : 16'h0003);
        end
        $display("count source test done");

        wr_reg(`TMR_OFS_CNT, 16'h1234);
        wr_reg(`TMR_OFS_GRA, 16'h1111);
        wr_reg(`TMR_OFS_PINF, 16'h0084);
        wr_reg(`TMR_OFS_CTRL, 16'h0040);
        u_pins.caps(1'b1, 1'b1);
        cyc(8);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_capture", v, 16'h1234);
        rd_reg(`TMR_OFS_BRA, v);
        chk("bra_capture", v, 16'h1111);
        rd_reg(`TMR_OFS_GRB, v);
        chk("grb_capture", v, 16'h1234);
        rd_reg(`TMR_OFS_CNT, v);
        chk("cnt_cap_clear", v, 16'h0000);
        $display("capture test done");

        wr_reg(`TMR_OFS_PINF, 16'h0000);
        wr_reg(`TMR_OFS_BRA, 16'h0AAA);
        wr_reg(`TMR_OFS_BMODE, 16'h0005);
        pulse_pair(1'b1);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_rsync_hold", v, 16'h1234);
        pulse_pair(1'b0);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_rsync", v, 16'h0AAA);
        wr_reg(`TMR_OFS_BRA, 16'h0BBB);
        wr_reg(`TMR_OFS_BMODE, 16'h000D);
        pulse_pair(1'b0);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_compl_hold", v, 16'h0AAA);
        pulse_pair(1'b1);
        rd_reg(`TMR_OFS_GRA, v);
        chk("gra_compl", v, 16'h0BBB);
        $display("pair buffer test done");
        final_report();
    end
endmodule

`default_nettype wire
